//--- data_mem_model.sv
`timescale 1ns/1ps
// ****
// Data memory model
// ****
module data_mem_model
    import pcstk_pkg::*;
(
    // Clock
    input wire logic               clk,
    // Memory port
    input wire logic [IADDR_W-1:0] addr,
    input wire logic               rd,
    input wire logic               wr,
    input wire logic [BYTE_W-1:0]  wdata,
    output logic     [BYTE_W-1:0]  rdata
);
    logic [BYTE_W-1:0] mem [2**IADDR_W];
    logic [BYTE_W-1:0] last_reg;
    // Known start pattern
    initial
    begin
        last_reg = 8'h00;
        for (int i = 0; i < 2**IADDR_W; i++)
            mem[i] = i[7:0] ^ 8'h5a;
    end
    // Writes land on the edge
    always @(posedge clk)
    begin
        if (wr)
            mem[addr] <= wdata;
        last_reg <= rdata;
    end
    // Data only while read is strobed
    assign rdata = rd ? mem[addr] : ~last_reg;
endmodule // data_mem_model

//--- pc_flow.sv
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Program counter is 13 bits; low byte held in a read/write register.
// [RQ2] Low byte register reads and writes like an ordinary data register.
// [RQ3] Upper five bits never directly accessed; loaded only from the high latch. Here they also take increment carry, operand bits, vector and stack values.
// [RQ4] Any reset clears the whole program counter.
// [RQ5] Writing the low byte also copies latch bits 4:0 into bits 12:8.
// [RQ6] Call or jump takes upper bits 12:11 from latch bits 4:3.
// [RQ7] Call or jump takes the lower eleven bits from the operand.
// [RQ8] Software must bump the latch itself on low-byte rollover; no carry.
// [RQ9] Eight-entry 13-bit return stack; its pointer is hidden.
// [RQ10] Call or interrupt vectoring pushes the program counter.
// [RQ11] Return, return-with-literal and return-from-interrupt pop into the counter.
// [RQ12] Pushes and pops leave the high latch unchanged.
// [RQ13] Stack wraps: ninth push overwrites first, tenth the second.
// [RQ14] No overflow or underflow indication; wrapping is silent.
// [RQ15] Indirect port is not physical; access goes to the pointed location.
// [RQ16] Indirect read of the port itself returns zero.
// [RQ17] Indirect write of the port itself changes no data.
// [RQ18] Indirect address is 9 bits: bank bit joined with 8-bit pointer.
// [RQ19] Bank bit is address bit 8; pointer forms bits 7 to 0.

module pc_flow
    import pcstk_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                 CLK_SYS,
    input  wire logic                 RESET,
    input  wire logic                 CE,
    // Decoder command
    input  wire pc_req_t              PC_REQ,
    input  wire logic                 LATCH_WR,
    input  wire logic [BYTE_W-1:0]    LATCH_WDATA,
    // Indirect access
    input  wire ind_req_t             IND_REQ,
    input  wire logic [BYTE_W-1:0]    POINTER_WDATA,
    input  wire logic                 POINTER_WR,
    input  wire logic                 INDIRECT_BANK_BIT,
    input  wire logic [BYTE_W-1:0]    MEM_RDATA,
    // Program counter view
    output logic      [PC_W-1:0]      PC,
    output logic      [BYTE_W-1:0]    PC_LOW_BYTE,
    output logic      [BYTE_W-1:0]    PC_HIGH_LATCH,
    output logic      [BYTE_W-1:0]    FILE_SELECT_POINTER,
    // Data memory side
    output logic      [IADDR_W-1:0]   MEM_ADDR,
    output logic                      MEM_RD,
    output logic                      MEM_WR,
    output logic      [BYTE_W-1:0]    MEM_WDATA,
    output logic      [BYTE_W-1:0]    IND_RDATA,
    output logic                      IND_RVALID
);

    // ****************************************
    // Internal state
    // ****************************************
    logic [BYTE_W-1:0]  pc_low_byte_reg;
    logic [HIGH_W-1:0]  pc_high_bits_reg;
    logic [BYTE_W-1:0]  pc_high_latch_reg;
    logic [BYTE_W-1:0]  file_select_pointer_reg;
    logic [PC_W-1:0]    pc_next;
    logic [PC_W-1:0]    pc_cur;
    logic [PC_W-1:0]    stack_top;
    logic [IADDR_W-1:0] ind_addr;
    logic               self_ref;
    logic               push;
    logic               pop;
    logic               pending_zero_reg;

    assign pc_cur = {pc_high_bits_reg, pc_low_byte_reg};

    // ****************************************
    // Return stack
    // ****************************************
    // Push the address to return to, i.e. the next instruction
    assign push = (PC_REQ.cmd == PC_CALL) || (PC_REQ.cmd == PC_VECTOR); // see [RQ10]
    assign pop  = (PC_REQ.cmd == PC_RETURN);                              // see [RQ11]

    // Hidden pointer, no status flags, silent wrap
    ret_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_W)
    ) u_stack (
        .clk       (CLK_SYS),
        .rst       (RESET),
        .ce        (CE),
        .push      (push),
        .pop       (pop),
        .push_data (pc_cur + 13'h0001),
        .top_data  (stack_top)
    ); // see [RQ9] see [RQ13] see [RQ14]

    // ****************************************
    // Next program counter
    // ****************************************
    always_comb
    begin
        pc_next = pc_cur;
        case (PC_REQ.cmd)
            PC_HOLD:
                pc_next = pc_cur;
            PC_INC:
                pc_next = pc_cur + 13'h0001;
            PC_WR_LOW:   // Upper bits from latch 4:0, no carry from low byte
                pc_next = {pc_high_latch_reg[HIGH_W-1:0], PC_REQ.low_data}; // see [RQ5] see [RQ8]
            PC_JUMP,
            PC_CALL:     // Page from latch 4:3, offset from operand
                pc_next = {pc_high_latch_reg[PAGE_MSB:PAGE_LSB],
                           PC_REQ.operand};                                  // see [RQ6] see [RQ7]
            PC_VECTOR:
                pc_next = {2'h0, PC_REQ.operand};
            PC_RETURN:
                pc_next = stack_top;                                         // see [RQ11]
            default:
                pc_next = pc_cur;
        endcase
    end

    // ****************************************
    // Program counter registers
    // ****************************************
    // Low byte, writable only through the decoder write command
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            pc_low_byte_reg <= PC_RESET[BYTE_W-1:0];                         // see [RQ4]
        else if (CE)
            pc_low_byte_reg <= pc_next[BYTE_W-1:0];                          // see [RQ1] see [RQ2]
    end

    // Upper bits, no direct write path
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            pc_high_bits_reg <= PC_RESET[PC_W-1:BYTE_W];                     // see [RQ4]
        else if (CE)
            pc_high_bits_reg <= pc_next[PC_W-1:BYTE_W];                      // see [RQ3]
    end

    // High latch, untouched by stack traffic
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            pc_high_latch_reg <= LATCH_RST;
        else if (CE && LATCH_WR)
            pc_high_latch_reg <= LATCH_WDATA;                                // see [RQ12]
    end

    // File select pointer
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            file_select_pointer_reg <= READ_ZERO;
        else if (CE && POINTER_WR)
            file_select_pointer_reg <= POINTER_WDATA;
    end

    // ****************************************
    // Indirect addressing
    // ****************************************
    assign ind_addr = {INDIRECT_BANK_BIT, file_select_pointer_reg};          // see [RQ18] see [RQ19]
    // Pointer aimed back at the port itself
    assign self_ref = (file_select_pointer_reg == IND_PORT_ADDR[BYTE_W-1:0]); // see [RQ15]

    // Memory strobes, suppressed on self reference
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            MEM_ADDR  <= '0;
            MEM_RD    <= 1'b0;
            MEM_WR    <= 1'b0;
            MEM_WDATA <= READ_ZERO;
        end
        else if (CE)
        begin
            MEM_ADDR  <= ind_addr;
            MEM_RD    <= IND_REQ.rd && !self_ref;
            MEM_WR    <= IND_REQ.wr && !self_ref;                            // see [RQ17]
            MEM_WDATA <= IND_REQ.wdata;
        end
    end

    // Remember a self-referencing read
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            pending_zero_reg <= 1'b0;
        else if (CE)
            pending_zero_reg <= IND_REQ.rd && self_ref;
    end

    // Read data returned one cycle after the memory strobe
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            IND_RDATA  <= READ_ZERO;
            IND_RVALID <= 1'b0;
        end
        else if (CE)
        begin
            IND_RVALID <= MEM_RD || pending_zero_reg;
            if (pending_zero_reg)
                IND_RDATA <= READ_ZERO;                                      // see [RQ16]
            else if (MEM_RD)
                IND_RDATA <= MEM_RDATA;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            PC                  <= PC_RESET;
            PC_LOW_BYTE         <= PC_RESET[BYTE_W-1:0];
            PC_HIGH_LATCH       <= LATCH_RST;
            FILE_SELECT_POINTER <= READ_ZERO;
        end
        else if (CE)
        begin
            PC                  <= pc_next;
            PC_LOW_BYTE         <= pc_next[BYTE_W-1:0];
            PC_HIGH_LATCH       <= LATCH_WR ? LATCH_WDATA : pc_high_latch_reg;
            FILE_SELECT_POINTER <= POINTER_WR ? POINTER_WDATA : file_select_pointer_reg;
        end
    end

endmodule // pc_flow

//--- pc_flow_chk.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module pc_flow_chk
    import pcstk_pkg::*;
(
    // Inputs
    input wire logic               CLK_SYS,
    input wire logic               RESET,
    input wire logic               CE,
    input wire logic               LATCH_WR,
    input wire pc_req_t            PC_REQ,
    input wire ind_req_t           IND_REQ,
    input wire logic               INDIRECT_BANK_BIT,
    input wire logic [BYTE_W-1:0]  MEM_RDATA,
    // Outputs
    input wire logic [PC_W-1:0]    PC,
    input wire logic [BYTE_W-1:0]  PC_LOW_BYTE,
    input wire logic [BYTE_W-1:0]  PC_HIGH_LATCH,
    input wire logic [BYTE_W-1:0]  FILE_SELECT_POINTER,
    input wire logic [IADDR_W-1:0] MEM_ADDR,
    input wire logic               MEM_RD,
    input wire logic               MEM_WR,
    input wire logic [BYTE_W-1:0]  IND_RDATA,
    input wire logic               IND_RVALID
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // Pointer aims at the port itself
    wire ptr0 = FILE_SELECT_POINTER == IND_PORT_ADDR[BYTE_W-1:0];
    // Self read: no strobe, then zero
    sequence s_self_rd;
        !MEM_RD ##1 (IND_RVALID && IND_RDATA == READ_ZERO);
    endsequence
    chk_low_write:
        assert property (CE && PC_REQ.cmd == PC_WR_LOW |=> PC ==
            {$past(PC_HIGH_LATCH[4:0]), $past(PC_REQ.low_data)}) else $error("bad low write");
    chk_page_load:
        assert property (CE && PC_REQ.cmd inside {PC_JUMP, PC_CALL} |=> PC ==
            {$past(PC_HIGH_LATCH[4:3]), $past(PC_REQ.operand)}) else $error("bad page load");
    chk_vector_load:
        assert property (CE && PC_REQ.cmd == PC_VECTOR |=> PC == {2'b00, $past(PC_REQ.operand)})
            else $error("bad vector load");
    chk_reset_clear:
        assert property (disable iff (1'b0) RESET |=> PC == PC_RESET) else $error("pc not cleared");
    chk_latch_keep:
        assert property (!LATCH_WR && PC_REQ.cmd inside {PC_CALL, PC_VECTOR, PC_RETURN}
            |=> $stable(PC_HIGH_LATCH)) else $error("latch moved on stack op");
    chk_low_view:
        assert property (PC_LOW_BYTE == PC[7:0]) else $error("low byte view wrong");
    chk_ind_addr:
        assert property (CE && IND_REQ.rd && !ptr0 |=> MEM_RD && MEM_ADDR ==
            {$past(INDIRECT_BANK_BIT), $past(FILE_SELECT_POINTER)}) else $error("bad address");
    chk_self_read:
        assert property (CE && IND_REQ.rd && ptr0 |=> s_self_rd) else $error("self read wrong");
    chk_self_write:
        assert property (CE && IND_REQ.wr && ptr0 |=> !MEM_WR) else $error("self write hit memory");
    chk_read_data:
        assert property (MEM_RD |=> IND_RVALID && IND_RDATA == $past(MEM_RDATA))
            else $error("read data lost");
endmodule // pc_flow_chk

//--- pcstk_pkg.sv
package pcstk_pkg;

    // ****************************************
    // Widths and depths
    // ****************************************
    localparam int PC_W        = 13;
    localparam int BYTE_W      = 8;
    localparam int HIGH_W      = 5;
    localparam int OPERAND_W   = 11;
    localparam int STACK_DEPTH = 8;
    localparam int IADDR_W     = 9;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int PAGE_LSB    = 3;   // Latch bits 4:3 select the page on call/jump
    localparam int PAGE_MSB    = 4;
    localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
    localparam logic [BYTE_W-1:0] READ_ZERO  = 8'h00;
    localparam logic [BYTE_W-1:0] LATCH_RST  = 8'h00;
    localparam logic [IADDR_W-1:0] IND_PORT_ADDR = 9'h000; // Address of the indirect port; only its low byte is compared

    // ****************************************
    // Program-counter load commands
    // ****************************************
    typedef enum logic [2:0] {
        PC_HOLD     = 3'h0,
        PC_INC      = 3'h1,
        PC_WR_LOW   = 3'h2,
        PC_JUMP     = 3'h3,
        PC_CALL     = 3'h4,
        PC_VECTOR   = 3'h5,
        PC_RETURN   = 3'h6
    } pc_cmd_t;

    // Command from the instruction decoder
    typedef struct packed {
        pc_cmd_t              cmd;
        logic [OPERAND_W-1:0] operand;   // Call/jump target or vector address
        logic [BYTE_W-1:0]    low_data;  // Value written to the low byte
    } pc_req_t;

    // Indirect access request
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [BYTE_W-1:0] wdata;
    } ind_req_t;

endpackage : pcstk_pkg

//--- program_counter_stack_indirect_tb_top.sv
`timescale 1ns/1ps
// ****
// Testbench top
// ****
module program_counter_stack_indirect_tb_top
    import pcstk_pkg::*;
;
    logic clk_sys, reset, ce, latch_wr, pointer_wr, bank, mem_rd, mem_wr, ind_rvalid;
    logic [7:0] latch_wdata, pointer_wdata, mem_rdata, low_byte, high_latch, fsp, mem_wdata;
    logic [7:0] ind_rdata, m_latch, shadow [512];
    logic [PC_W-1:0] pc, m_pc, stk [8];
    logic [IADDR_W-1:0] mem_addr;
    pc_req_t pc_req;
    ind_req_t ind_req;
    logic [20:0] pc_q [$];
    logic [7:0] ind_q [$];
    int sp, bad_count, checks_done;
    pc_flow i_pc_flow (.CLK_SYS(clk_sys), .RESET(reset), .CE(ce), .PC_REQ(pc_req),
        .LATCH_WR(latch_wr), .LATCH_WDATA(latch_wdata), .IND_REQ(ind_req),
        .POINTER_WDATA(pointer_wdata), .POINTER_WR(pointer_wr), .INDIRECT_BANK_BIT(bank),
        .MEM_RDATA(mem_rdata), .PC(pc), .PC_LOW_BYTE(low_byte), .PC_HIGH_LATCH(high_latch),
        .FILE_SELECT_POINTER(fsp), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
        .MEM_WDATA(mem_wdata), .IND_RDATA(ind_rdata), .IND_RVALID(ind_rvalid));
    data_mem_model i_data_mem_model (.clk(clk_sys), .addr(mem_addr), .rd(mem_rd),
        .wr(mem_wr), .wdata(mem_wdata), .rdata(mem_rdata));
    // Clock
    initial
    begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Compare and count
    task check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One counter command, CE random when asked; no carry into latch
    task step(input pc_cmd_t c, input bit rnd);
        logic [10:0] op;
        logic [7:0] lo, lw;
        logic e, w;
        op = 11'($urandom);
        lo = 8'($urandom);
        lw = 8'($urandom);
        w = 1'($urandom);
        e = rnd ? ($urandom % 8 != 0) : 1'b1;
        if (e)
            case (c)
                PC_INC: m_pc = m_pc + 1;
                PC_WR_LOW: m_pc = {m_latch[4:0], lo};
                PC_JUMP: m_pc = {m_latch[4:3], op};
                PC_CALL, PC_VECTOR:
                begin
                    stk[sp] = m_pc + 1;
                    sp = (sp + 1) % 8;
                    m_pc = (c == PC_CALL) ? {m_latch[4:3], op} : {2'b00, op};
                end
                PC_RETURN:
                begin
                    sp = (sp + 7) % 8;
                    m_pc = stk[sp];
                end
                default: ;
            endcase
        if (e && w)
            m_latch = lw;
        pc_q.push_back({m_latch, m_pc});
        ce = e;
        latch_wr = w;
        latch_wdata = lw;
        pc_req = '{c, op, lo};
        @(posedge clk_sys);
        #1;
    endtask
    // Pointer load, then one indirect access
    task ind;
        logic [7:0] p, wd;
        logic b, wo;
        p = 8'($urandom % 8);
        b = 1'($urandom);
        wo = 1'($urandom);
        wd = 8'($urandom);
        pointer_wr = 1;
        pointer_wdata = p;
        bank = b;
        @(posedge clk_sys);
        #1;
        pointer_wr = 0;
        ind_req = '{!wo, wo, wd};
        if (!wo)
            ind_q.push_back(p == 0 ? READ_ZERO : shadow[{b, p}]);
        else if (p != 0)
            shadow[{b, p}] = wd;
        @(posedge clk_sys);
        #1;
        ind_req = '0;
    endtask
    // Result watcher
    always @(posedge clk_sys)
    begin
        #0.5;
        if (pc_q.size() != 0)
            check({3'b0, high_latch, pc}, pc_q.pop_front());
        if (ind_rvalid)
            check(ind_rdata, ind_q.size() ? ind_q.pop_front() : 8'hxx);
    end
    // Watchdog
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        bad_count++;
        end_of_test;
    end
    // Main sequence
    initial
    begin
        void'($urandom(87));
        {reset, ce, latch_wr, pointer_wr, bank} = 5'b11000;
        {latch_wdata, pointer_wdata} = 16'h0000;
        pc_req = '{PC_HOLD, 11'h000, 8'h00};
        ind_req = '0;
        {m_pc, m_latch, sp} = 0;
        for (int i = 0; i < 512; i++)
            shadow[i] = i[7:0] ^ 8'h5a;
        repeat (20) @(posedge clk_sys);
        #1;
        reset = 0;
        check({high_latch, pc}, 24'h0);
        repeat (10) step(PC_CALL, 0);
        repeat (9) step(PC_RETURN, 0);
        repeat (80) step(pc_cmd_t'($urandom % 7), 1);
        pc_req.cmd = PC_HOLD;
        {ce, latch_wr, reset} = 3'b101;
        @(posedge clk_sys);
        #1;
        reset = 0;
        check({high_latch, pc}, 24'h0);
        repeat (40) ind();
        repeat (3) @(posedge clk_sys);
        end_of_test;
    end
endmodule // program_counter_stack_indirect_tb_top

bind pc_flow pc_flow_chk i_pc_flow_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE),
    .LATCH_WR(LATCH_WR), .PC_REQ(PC_REQ), .IND_REQ(IND_REQ),
    .INDIRECT_BANK_BIT(INDIRECT_BANK_BIT), .MEM_RDATA(MEM_RDATA), .PC(PC),
    .PC_LOW_BYTE(PC_LOW_BYTE), .PC_HIGH_LATCH(PC_HIGH_LATCH),
    .FILE_SELECT_POINTER(FILE_SELECT_POINTER), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .IND_RDATA(IND_RDATA), .IND_RVALID(IND_RVALID));

//--- ret_stack.sv
`timescale 1ns/1ps

module ret_stack
    import pcstk_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W
)
(
    // Clock and control
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Stack operations
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] ptr_reg;

    // ****************************************
    // Hidden pointer, wraps silently
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (rst)
            ptr_reg <= '0;
        else if (ce && push)
            ptr_reg <= ptr_reg + 1'b1;   // Overwrites oldest after DEPTH pushes
        else if (ce && pop)
            ptr_reg <= ptr_reg - 1'b1;
    end

    // Entry storage
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem[ptr_reg] <= push_data;
    end

    // Most recent entry
    assign top_data = mem[ptr_reg - 1'b1];

endmodule // ret_stack
